/* File: rtl/wiper_pkg.sv */
package wiper_pkg;
	// Wishbone register byte addresses
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_WIPER = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	// Command field position in the command register
	localparam int CMD_LSB = 10;
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
	localparam logic [3:0] CMD_PROGRAM = 4'h3;
	localparam logic [3:0] CMD_SOFT_RESET = 4'h4;
	localparam logic [3:0] CMD_WRITE_CTRL = 4'h7;
	localparam logic [3:0] CMD_SHUTDOWN = 4'h9;
	// Control bit positions
	localparam int CTRL_OTP_EN = 0;
	localparam int CTRL_WIPER_WE = 1;
	localparam int CTRL_TOL_DIS = 2;
	localparam int CTRL_PROG_OK = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Memory layout
	localparam int OTP_DEPTH = 50;
	localparam logic [5:0] OTP_FIRST = 6'h01;
	// Program busy time
	localparam int PROG_TIME_MS = 350;
	localparam int CLK_HZ = 40000000;
	localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
endpackage : wiper_pkg

/* File: rtl/tap_decoder.sv */
`timescale 1ns/100ps
module tap_decoder #(
	parameter int CODE_W = 10
) (
	input wire logic [CODE_W-1:0] code_in, // Wiper code
	input wire logic shutdown_in, // Open terminal A
	output logic [(1<<CODE_W)-1:0] tap_out // One-hot tap select
);
	localparam int TAPS = 1 << CODE_W;
	assign tap_out = shutdown_in ? '0 : (TAPS)'(1) << code_in;
endmodule : tap_decoder

/* File: rtl/rheostat_wiper_control.sv */
`timescale 1ns/100ps
module rheostat_wiper_control #(
	parameter int CODE_W = 10,
	parameter int PROG_CYCLES = wiper_pkg::PROG_CYCLES
) (
	input wire logic clk_sys_in, // 40 MHz clock
	input wire logic nrst_in, // Power-on reset, active low
	input wire logic nrst_pin_in, // Reset pin, active low, async
	input wire logic wb_cyc_in, // Wishbone cycle
	input wire logic wb_stb_in, // Wishbone strobe
	input wire logic wb_we_in, // Wishbone write
	input wire logic [3:0] wb_adr_in, // Wishbone byte address
	input wire logic [3:0] wb_sel_in, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_in, // Wishbone write data
	output logic [31:0] wb_dat_out, // Wishbone read data
	output logic wb_ack_out, // Wishbone acknowledge
	output logic busy_out, // Boot or program cycle active
	output logic shutdown_out, // Terminal A disconnected
	output logic tol_cal_en_out, // Tolerance calibration on
	output logic [CODE_W-1:0] wiper_out, // Current wiper code
	output logic [(1<<CODE_W)-1:0] tap_out // One-hot tap select
);
	localparam logic [CODE_W-1:0] MIDSCALE = CODE_W'(1) << (CODE_W - 1);
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_PROG} state_t;

	////////////////////////////////////////////////////////////////
	// Reset pin synchroniser and falling-edge detection
	logic pin_meta, pin_sync, pin_prev;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= nrst_pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	wire pin_reset = pin_prev & ~pin_sync;

	////////////////////////////////////////////////////////////////
	// Wishbone decode
	state_t state;
	logic [CODE_W-1:0] wiper;
	logic [3:0] ctrl;
	logic shutdown;
	logic [5:0] last_loc;
	logic [CNT_W-1:0] prog_cnt;
	logic [CODE_W-1:0] otp_mem [1:wiper_pkg::OTP_DEPTH];

	wire bus_req = wb_cyc_in & wb_stb_in;
	wire bus_take = bus_req & ~wb_ack_out & (state == ST_RUN);
	wire bus_wr = bus_take & wb_we_in & wb_sel_in[0] & wb_sel_in[1];
	wire cmd_wr = bus_wr & (wb_adr_in == wiper_pkg::ADDR_CMD);
	wire [CODE_W-1:0] cmd_data = wb_dat_in[CODE_W-1:0];
	wire otp_full = (last_loc == 6'(wiper_pkg::OTP_DEPTH));

	// Command field match
	function automatic logic is_cmd(input logic [31:0] dat, input logic [3:0] code);
		is_cmd = (dat[wiper_pkg::CMD_LSB +: 4] == code);
	endfunction : is_cmd

	wire do_wiper = cmd_wr & is_cmd(wb_dat_in, wiper_pkg::CMD_WRITE_WIPER) & ctrl[wiper_pkg::CTRL_WIPER_WE];
	// A pin reset in the same cycle wins, so no program is half started
	wire do_prog = cmd_wr & is_cmd(wb_dat_in, wiper_pkg::CMD_PROGRAM) & ctrl[wiper_pkg::CTRL_OTP_EN]
		& ~otp_full & ~pin_reset;
	wire do_soft = cmd_wr & is_cmd(wb_dat_in, wiper_pkg::CMD_SOFT_RESET);
	wire do_ctrl = cmd_wr & is_cmd(wb_dat_in, wiper_pkg::CMD_WRITE_CTRL);
	wire do_sd = cmd_wr & is_cmd(wb_dat_in, wiper_pkg::CMD_SHUTDOWN);
	wire any_reset = do_soft | pin_reset;
	wire [5:0] next_loc = last_loc + 6'h01;

	// stored value, or midscale if never programmed
	wire [CODE_W-1:0] stored_code = (last_loc == 6'h00) ? MIDSCALE : otp_mem[last_loc];

	wire [31:0] rd_data;
	assign rd_data = (wb_adr_in == wiper_pkg::ADDR_WIPER) ? 32'(wiper) :
		(wb_adr_in == wiper_pkg::ADDR_CTRL) ? {28'h0000000, ctrl} :
		(wb_adr_in == wiper_pkg::ADDR_STATUS) ? {24'h000000, shutdown, (state == ST_PROG), last_loc} :
		32'h00000000;

	////////////////////////////////////////////////////////////////
	// Bus answer
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= bus_take;
			if (bus_take) begin
				wb_dat_out <= rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// OTP memory array, written only by program commands
	always_ff @(posedge clk_sys_in) begin
		if (do_prog) begin
			otp_mem[next_loc] <= wiper;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control state
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ST_BOOT;
			wiper <= MIDSCALE;
			ctrl <= wiper_pkg::CTRL_RESET;
			shutdown <= 1'b0;
			last_loc <= 6'h00;
			prog_cnt <= '0;
		end else begin
			case (state)
				ST_BOOT: begin
					wiper <= stored_code;
					state <= ST_RUN;
				end
				ST_PROG: begin
					// pin reset still acts while busy
					if (pin_reset) begin
						wiper <= stored_code;
						shutdown <= 1'b0;
					end
					if (prog_cnt == CNT_W'(1)) begin
						ctrl[wiper_pkg::CTRL_PROG_OK] <= 1'b1;
						state <= ST_RUN;
					end
					prog_cnt <= prog_cnt - CNT_W'(1);
				end
				default: begin
					if (any_reset) begin
						wiper <= stored_code;
						shutdown <= 1'b0;
					end else begin
						if (do_wiper) begin
							wiper <= cmd_data;
						end
						if (do_ctrl) begin
							ctrl[2:0] <= wb_dat_in[2:0];
						end
						if (do_sd) begin
							shutdown <= wb_dat_in[0];
						end
						if (do_prog) begin
							last_loc <= next_loc;
							ctrl[wiper_pkg::CTRL_PROG_OK] <= 1'b0;
							prog_cnt <= CNT_W'(PROG_CYCLES);
							state <= ST_PROG;
						end
					end
				end
			endcase
		end
	end

	assign busy_out = (state != ST_RUN);
	assign shutdown_out = shutdown;
	// bit two low keeps calibration active
	assign tol_cal_en_out = ~ctrl[wiper_pkg::CTRL_TOL_DIS];
	// shutdown never touches the wiper code
	assign wiper_out = wiper;

	////////////////////////////////////////////////////////////////
	// Tap decode
	// one of 2^CODE_W taps
	tap_decoder #(
		.CODE_W(CODE_W)
	) u_tap (
		.code_in(wiper),
		.shutdown_in(shutdown),
		.tap_out(tap_out)
	);

	////////////////////////////////////////////////////////////////
	// Checks
	a_busy_no_ack: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_PROG) |=> !wb_ack_out) else $error("ack given while busy");
	a_prog_enters_busy: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		do_prog |=> (state == ST_PROG)) else $error("program did not start busy cycle");
	a_prog_locks_wiper: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_PROG && !pin_reset) |=> $stable(wiper)) else $error("wiper changed while busy");
	a_soft_reset_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		do_soft |=> (wiper == $past(stored_code))) else $error("soft reset did not reload");
	a_reset_wakes: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		any_reset |=> !shutdown) else $error("reset left shutdown set");
	a_sd_enter: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(do_sd && wb_dat_in[0] && !any_reset) |=> shutdown) else $error("shutdown not entered");
	a_sd_keeps_code: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(do_sd && !do_wiper) |=> $stable(wiper)) else $error("shutdown changed wiper");
	a_wp_blocks: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(cmd_wr && !ctrl[wiper_pkg::CTRL_WIPER_WE] && !any_reset) |=> $stable(wiper))
		else $error("locked wiper was written");
	a_prog_loc_step: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		do_prog |=> (last_loc == $past(last_loc) + 6'h01)) else $error("location not advanced");
	a_prog_ok_bit: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_PROG && prog_cnt == CNT_W'(1)) |=> ctrl[wiper_pkg::CTRL_PROG_OK])
		else $error("success bit not set");

	////////////////////////////////////////////////////////////////
	// Boot and reset checks
	a_boot_restore: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_BOOT) |=> (wiper == $past(stored_code)))
		else $error("boot did not restore stored code");
	a_boot_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_BOOT) |=> (state == ST_RUN))
		else $error("boot lasted more than one cycle");
	a_midscale_empty: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(any_reset && last_loc == 6'h00) |=> (wiper == MIDSCALE))
		else $error("empty memory reset not midscale");
	a_pin_reset_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		pin_reset |=> (wiper == $past(stored_code)))
		else $error("pin reset did not reload");
	a_pin_wakes: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		pin_reset |=> !shutdown)
		else $error("pin reset left shutdown set");
	a_reset_keeps_ctrl: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		any_reset |=> $stable(ctrl[2:0]))
		else $error("reset changed control bits");

	////////////////////////////////////////////////////////////////
	// Bus checks
	a_take_acked: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		bus_take |=> wb_ack_out)
		else $error("taken access not acknowledged");
	a_ack_pulse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");

	////////////////////////////////////////////////////////////////
	// Command checks
	a_wiper_write: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(do_wiper && !pin_reset) |=> (wiper == $past(cmd_data)))
		else $error("enabled wiper write lost");
	a_ctrl_write: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(do_ctrl && !any_reset) |=> (ctrl[2:0] == $past(wb_dat_in[2:0])))
		else $error("control write lost");
	a_ctrl_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		!do_ctrl |=> $stable(ctrl[2:0]))
		else $error("control bits changed unasked");
	a_sd_leave: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(do_sd && !wb_dat_in[0]) |=> !shutdown)
		else $error("shutdown not left");
	a_sd_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(!do_sd && !any_reset) |=> $stable(shutdown))
		else $error("shutdown changed unasked");

	////////////////////////////////////////////////////////////////
	// Program checks
	a_prog_clears_ok: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		do_prog |=> !ctrl[wiper_pkg::CTRL_PROG_OK])
		else $error("success bit not cleared at start");
	a_prog_count: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_PROG && prog_cnt != CNT_W'(1)) |=> (state == ST_PROG))
		else $error("busy cycle ended early");
	a_busy_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(state == ST_PROG) |-> busy_out)
		else $error("busy flag low while programming");
	a_prog_writes_mem: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		do_prog |=> (otp_mem[last_loc] == $past(wiper)))
		else $error("program did not store wiper code");
	a_loc_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		!do_prog |=> $stable(last_loc))
		else $error("location moved without program");
	a_otp_gate: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(cmd_wr && is_cmd(wb_dat_in, wiper_pkg::CMD_PROGRAM) && !ctrl[wiper_pkg::CTRL_OTP_EN])
		|=> ((state == ST_RUN) && $stable(last_loc)))
		else $error("program ran while memory locked");

	////////////////////////////////////////////////////////////////
	// Tap checks
	a_tap_onehot: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		!shutdown |-> $onehot(tap_out))
		else $error("tap select not one-hot");
	a_tap_off: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		shutdown |-> (tap_out == '0))
		else $error("tap selected in shutdown");
endmodule : rheostat_wiper_control

/* File: verification/wb_host_model.sv */
`timescale 1ns/100ps
module wb_host_model (
	input wire logic clk_in, // Bus clock
	input wire logic ack_in, // Slave acknowledge
	output logic cyc_out = 1'b0, // Cycle
	output logic stb_out = 1'b0, // Strobe
	output logic we_out = 1'b0, // Write
	output logic [3:0] adr_out = 4'h0, // Address
	output logic [3:0] sel_out = 4'hF, // Byte lanes
	output logic [31:0] dat_out = 32'h0 // Write data
);
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic ok);
		ok = 1'b0;
		@(posedge clk_in);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= w;
		adr_out <= a;
		dat_out <= d;
		for (int n = 0; n < 200 && !ok; n++) begin
			@(posedge clk_in);
			ok = (ack_in === 1'b1);
		end
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		adr_out <= ~a;
		dat_out <= ~d;
		@(posedge clk_in);
	endtask : xfer
endmodule : wb_host_model

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic clk_sys_in, nrst_in = 1'b0, nrst_pin_in = 1'b1;
	logic cyc, stb, we, ack, busy, sd, tce;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat;
	logic [9:0] wiper, v, v2;
	logic [1023:0] tap;
	logic [31:0] q[$];
	int n_mismatch = 0, compares = 0, seed = 66;
	////////////////////////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	wb_host_model host_u (.clk_in(clk_sys_in), .ack_in(ack), .cyc_out(cyc), .stb_out(stb), .we_out(we),
		.adr_out(adr), .sel_out(sel), .dat_out(wdat));
	rheostat_wiper_control #(.CODE_W(10), .PROG_CYCLES(20)) dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.nrst_pin_in(nrst_pin_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .busy_out(busy),
		.shutdown_out(sd), .tol_cal_en_out(tce), .wiper_out(wiper), .tap_out(tap));
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic print_verdict;
		if (q.size() != 0) n_mismatch++;
		if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic ok;
		host_u.xfer(w, a, d, ok);
		if (!ok) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : bus
	task automatic cmd(input logic [3:0] c, input logic [9:0] d);
		bus(1'b1, wiper_pkg::ADDR_CMD, (32'(c) << wiper_pkg::CMD_LSB) | 32'(d));
	endtask : cmd
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Read data checked against the oldest note
	always @(posedge clk_sys_in)
		if (ack === 1'b1 && we === 1'b0) chk("rdata", q.size() != 0 ? q.pop_front() : 32'hDEADBEEF, rdat);
	////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		v = 10'({$random(seed)} % 512);
		v2 = ~v;
		rd(wiper_pkg::ADDR_WIPER, 32'h200);
		rd(wiper_pkg::ADDR_CTRL, 32'h0);
		chk("tol_cal", 32'h1, 32'(tce));
		cmd(wiper_pkg::CMD_WRITE_WIPER, v);
		rd(wiper_pkg::ADDR_WIPER, 32'h200);
		cmd(wiper_pkg::CMD_PROGRAM, 10'h0);
		chk("busy_locked", 32'h0, 32'(busy));
		rd(4'h2, 32'h0);
		cmd(wiper_pkg::CMD_WRITE_CTRL, 10'h3);
		cmd(wiper_pkg::CMD_WRITE_WIPER, v2);
		cmd(wiper_pkg::CMD_SOFT_RESET, 10'h0);
		rd(wiper_pkg::ADDR_WIPER, 32'h200);
		cmd(wiper_pkg::CMD_WRITE_WIPER, v);
		rd(wiper_pkg::ADDR_WIPER, 32'(v));
		chk("tap", 32'h1, 32'(tap === (1024'h1 << v)));
		cmd(wiper_pkg::CMD_PROGRAM, 10'h0);
		chk("busy", 32'h1, 32'(busy));
		rd(wiper_pkg::ADDR_STATUS, 32'h01);
		rd(wiper_pkg::ADDR_CTRL, 32'hB);
		cmd(wiper_pkg::CMD_SHUTDOWN, 10'h1);
		chk("shutdown", 32'h1, 32'(sd));
		chk("tap_off", 32'h0, 32'(|tap));
		cmd(wiper_pkg::CMD_WRITE_WIPER, v2);
		rd(wiper_pkg::ADDR_WIPER, 32'(v2));
		cmd(wiper_pkg::CMD_SOFT_RESET, 10'h0);
		rd(wiper_pkg::ADDR_WIPER, 32'(v));
		chk("wiper_out", 32'(v), 32'(wiper));
		chk("shutdown", 32'h0, 32'(sd));
		cmd(wiper_pkg::CMD_SHUTDOWN, 10'h1);
		cmd(wiper_pkg::CMD_SHUTDOWN, 10'h0);
		chk("shutdown", 32'h0, 32'(sd));
		cmd(wiper_pkg::CMD_SHUTDOWN, 10'h1);
		cmd(wiper_pkg::CMD_WRITE_CTRL, 10'h3);
		cmd(wiper_pkg::CMD_WRITE_WIPER, v2);
		nrst_pin_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		nrst_pin_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		rd(wiper_pkg::ADDR_WIPER, 32'(v));
		chk("wiper_out", 32'(v), 32'(wiper));
		chk("shutdown", 32'h0, 32'(sd));
		cmd(wiper_pkg::CMD_WRITE_CTRL, 10'h7);
		chk("tol_cal", 32'h0, 32'(tce));
		print_verdict();
	end
endmodule : testbench
